// >>> scr_top.sv
// configuration registers with video timing, irq routing and serial divider
`default_nettype none
`include "scr_defines.svh"

module scr_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              main_clock_en,
    input  wire logic              interrupt_input_a,
    input  wire logic              interrupt_input_b,
    input  wire logic              video_req,
    input  wire logic              video_page_hit,
    input  wire logic              video_is_psram,
    output logic                   display_enable,
    output logic                   expansion_owns_display,
    output logic [19:0]            display_window_base,
    output logic [7:0]             irq_lines,
    output logic                   serial_clock,
    output logic                   video_ras,
    output logic                   video_cas,
    output logic                   video_precharge,
    output logic                   video_cs,
    output logic                   video_done,
    output logic                   video_speed_error
);

    if (ADDR_W < 7) begin : g_addr_chk
        $error("scr_top: address too narrow for map");
    end

    // ****************************************
    // register bus slave
    // ****************************************
    logic [7:0] display_q, route_q, div_q;
    logic       aw_held_q, w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic       wstrb0_q;
    logic       wr_fire, wr_hit;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_hit  = awaddr_q == ADDR_W'(`SCR_ADDR_DISPLAY)
                  || awaddr_q == ADDR_W'(`SCR_ADDR_IRQ_ROUTE)
                  || awaddr_q == ADDR_W'(`SCR_ADDR_SER_DIV);

    // address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wbyte_q   <= 8'h00;
            wstrb0_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wbyte_q  <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SCR_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `SCR_RESP_OKAY : `SCR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // reserved bits are masked so they always read as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            display_q <= `SCR_RST_DISPLAY;
            route_q   <= `SCR_RST_IRQ_ROUTE;
            div_q     <= `SCR_RST_SER_DIV;
        end else if (wr_fire && wstrb0_q) begin
            if (awaddr_q == ADDR_W'(`SCR_ADDR_DISPLAY)) begin
                display_q <= wbyte_q & `SCR_DISP_MASK;
            end
            if (awaddr_q == ADDR_W'(`SCR_ADDR_IRQ_ROUTE)) begin
                route_q <= wbyte_q & `SCR_ROUTE_MASK;
            end
            if (awaddr_q == ADDR_W'(`SCR_ADDR_SER_DIV)) begin
                div_q <= wbyte_q;
            end
        end
    end

    scr_pkg::scr_vid_e vid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SCR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `SCR_RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_W'(`SCR_ADDR_DISPLAY):
                    s_axi_rdata <= {24'h00_0000, display_q};
                ADDR_W'(`SCR_ADDR_IRQ_ROUTE):
                    s_axi_rdata <= {24'h00_0000, route_q};
                ADDR_W'(`SCR_ADDR_SER_DIV):
                    s_axi_rdata <= {24'h00_0000, div_q};
                ADDR_W'(`SCR_ADDR_STATUS):
                    s_axi_rdata <= {29'h0000_0000, video_speed_error,
                                    serial_clock, vid_q != scr_pkg::SCR_V_IDLE};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `SCR_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // display control
    // ****************************************
    // display off frees window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            display_enable         <= 1'b1;
            expansion_owns_display <= 1'b0;
            display_window_base    <= 20'h0_0000;
        end else begin
            display_enable         <= !display_q[`SCR_DISP_OFF_BIT];
            expansion_owns_display <= display_q[`SCR_DISP_OFF_BIT];
            display_window_base    <= `SCR_DISP_BASE;
        end
    end

    // ****************************************
    // video access timing, half-cycle units
    // ****************************************
    // one aclk here is half a processor cycle so 0.5 figures are exact
    logic [1:0]        speed;
    scr_pkg::scr_half_t ras_len, col_len, pre_len, cas_len, spre_len, cs_len;
    scr_pkg::scr_half_t cnt_q;
    logic              in_page_q;

    assign speed = display_q[`SCR_SPEED_HI:`SCR_SPEED_LO];

    always_comb begin
        unique case (speed)
            2'b00: begin
                ras_len = `SCR_FP_RAS_00;
                col_len = `SCR_FP_COL_00;
                pre_len = `SCR_FP_PRE_00;
                cas_len = `SCR_FP_CAS_00;
            end
            2'b01: begin
                ras_len = `SCR_FP_RAS_01;
                col_len = `SCR_FP_COL_01;
                pre_len = `SCR_FP_PRE_01;
                cas_len = `SCR_FP_CAS_01;
            end
            default: begin
                ras_len = `SCR_FP_RAS_10;
                col_len = `SCR_FP_COL_10;
                pre_len = `SCR_FP_PRE_10;
                cas_len = `SCR_FP_CAS_10;
            end
        endcase
    end

    always_comb begin
        unique case (speed)
            2'b00: begin
                spre_len = `SCR_SR_PRE_00;
                cs_len   = `SCR_SR_CS_00;
            end
            2'b01: begin
                spre_len = `SCR_SR_PRE_01;
                cs_len   = `SCR_SR_CS_01;
            end
            2'b10: begin
                spre_len = `SCR_SR_PRE_10;
                cs_len   = `SCR_SR_CS_10;
            end
            default: begin
                spre_len = `SCR_SR_PRE_11;
                cs_len   = `SCR_SR_CS_11;
            end
        endcase
    end

    assign video_speed_error = !video_is_psram && speed == 2'b11;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vid_q      <= scr_pkg::SCR_V_IDLE;
            cnt_q      <= 4'd0;
            in_page_q  <= 1'b0;
            video_done <= 1'b0;
        end else begin
            video_done <= 1'b0;
            unique case (vid_q)
                scr_pkg::SCR_V_IDLE: begin
                    if (!video_req) begin
                        in_page_q <= 1'b0;
                    end else if (video_is_psram) begin
                        vid_q <= scr_pkg::SCR_V_SPRE;
                        cnt_q <= spre_len - 4'd1;
                    end else if (!video_speed_error) begin
                        if (in_page_q && video_page_hit) begin
                            vid_q <= scr_pkg::SCR_V_PRE;
                            cnt_q <= pre_len - 4'd1;
                        end else begin
                            vid_q <= scr_pkg::SCR_V_RAS;
                            cnt_q <= ras_len - 4'd1;
                        end
                    end
                end
                scr_pkg::SCR_V_RAS: begin
                    if (cnt_q != 4'd0) begin
                        cnt_q <= cnt_q - 4'd1;
                    end else begin
                        vid_q <= scr_pkg::SCR_V_CAS;
                        cnt_q <= col_len - 4'd1;
                    end
                end
                scr_pkg::SCR_V_PRE: begin
                    if (cnt_q != 4'd0) begin
                        cnt_q <= cnt_q - 4'd1;
                    end else begin
                        vid_q <= scr_pkg::SCR_V_CAS;
                        cnt_q <= cas_len - 4'd1;
                    end
                end
                scr_pkg::SCR_V_SPRE: begin
                    if (cnt_q != 4'd0) begin
                        cnt_q <= cnt_q - 4'd1;
                    end else begin
                        vid_q <= scr_pkg::SCR_V_CS;
                        cnt_q <= cs_len - 4'd1;
                    end
                end
                scr_pkg::SCR_V_CAS, scr_pkg::SCR_V_CS: begin
                    if (cnt_q != 4'd0) begin
                        cnt_q <= cnt_q - 4'd1;
                    end else begin
                        vid_q      <= scr_pkg::SCR_V_IDLE;
                        in_page_q  <= vid_q == scr_pkg::SCR_V_CAS;
                        video_done <= 1'b1;
                    end
                end
                default: vid_q <= scr_pkg::SCR_V_IDLE;
            endcase
        end
    end

    assign video_ras       = vid_q == scr_pkg::SCR_V_RAS;
    assign video_cas       = vid_q == scr_pkg::SCR_V_CAS;
    assign video_precharge = vid_q == scr_pkg::SCR_V_PRE
                          || vid_q == scr_pkg::SCR_V_SPRE;
    assign video_cs        = vid_q == scr_pkg::SCR_V_CS;

    // ****************************************
    // interrupt routing
    // ****************************************
    logic [2:0] route_a, route_b;
    assign route_a = route_q[`SCR_RA_HI:`SCR_RA_LO];
    assign route_b = route_q[`SCR_RB_HI:`SCR_RB_LO];

    // per-line decode, 0 and 2 drive nothing
    for (genvar i = 0; i < 8; i++) begin : g_irq
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                irq_lines[i] <= 1'b0;
            end else begin
                irq_lines[i] <= (i != 0 && i != 2)
                    && ((route_a == 3'(i) && interrupt_input_a)
                     || (route_b == 3'(i) && interrupt_input_b));
            end
        end
    end

    // ****************************************
    // serial clock divider
    // ****************************************
    logic [3:0] div_cnt_q, div_lim;
    logic       div_wr;
    assign div_lim = serial_clock ? div_q[7:4] : div_q[3:0];
    // a rewrite restarts the phase so the count never overruns a lower limit
    assign div_wr  = wr_fire && wstrb0_q
                  && awaddr_q == ADDR_W'(`SCR_ADDR_SER_DIV);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_clock <= 1'b1;
            div_cnt_q    <= 4'd0;
        end else begin
            if (main_clock_en && div_cnt_q != div_lim) begin
                div_cnt_q <= div_cnt_q + 4'd1;
            end else if (main_clock_en) begin
                div_cnt_q    <= 4'd0;
                serial_clock <= !serial_clock;
            end
            if (div_wr) begin
                div_cnt_q <= 4'd0;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    display_map_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        display_q[`SCR_DISP_OFF_BIT] |=> expansion_owns_display
            && !display_enable)
        else $error("display window not released");

    irq_reserved_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !irq_lines[0] && !irq_lines[2])
        else $error("reserved interrupt driven");

    irq_route_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (route_b == 3'd5 && interrupt_input_b) |=> irq_lines[5])
        else $error("line b not routed");

    fp_first_ras_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (vid_q == scr_pkg::SCR_V_IDLE && video_req && !video_is_psram
         && !video_speed_error && !(in_page_q && video_page_hit))
        |=> vid_q == scr_pkg::SCR_V_RAS)
        else $error("first page access skipped ras");

    fp_speed00_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ($rose(vid_q == scr_pkg::SCR_V_PRE) && speed == 2'b00)
        |=> vid_q == scr_pkg::SCR_V_CAS ##3 vid_q == scr_pkg::SCR_V_IDLE)
        else $error("fast page 00 timing wrong");

    sr_speed11_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ($rose(vid_q == scr_pkg::SCR_V_CS) && speed == 2'b11)
        |-> video_cs [*8] ##1 video_cs [*3] ##1 !video_cs)
        else $error("psram 11 chip select length wrong");

    speed_sel_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ($rose(vid_q == scr_pkg::SCR_V_SPRE) && speed == 2'b01)
        |-> ##3 video_precharge ##1 video_cs)
        else $error("speed code not applied");

    ser_high_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (main_clock_en && serial_clock && div_cnt_q == div_q[7:4])
        |=> !serial_clock)
        else $error("serial high phase length wrong");

    ser_low_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!serial_clock && div_cnt_q < div_q[3:0]) |=> !serial_clock)
        else $error("serial low phase ended early");

    ser_range_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        div_cnt_q <= (serial_clock ? div_q[7:4] : div_q[3:0]))
        else $error("divider counter out of range");

    ser_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (serial_clock && div_cnt_q < div_q[7:4]) |=> serial_clock)
        else $error("serial high phase ended early");

endmodule
`default_nettype wire

// >>> scr_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// ****************************************
// register byte addresses (index * 4)
// ****************************************
`define SCR_IDX_DISPLAY     8'h07
`define SCR_IDX_IRQ_ROUTE   8'h08
`define SCR_IDX_SER_DIV     8'h0F
`define SCR_ADDR_DISPLAY    12'h01C
`define SCR_ADDR_IRQ_ROUTE  12'h020
`define SCR_ADDR_SER_DIV    12'h03C
`define SCR_ADDR_STATUS     12'h040

// ****************************************
// reset values and field positions
// ****************************************
`define SCR_RST_DISPLAY     8'h00
`define SCR_RST_IRQ_ROUTE   8'h00
`define SCR_RST_SER_DIV     8'h88
`define SCR_DISP_OFF_BIT    7
`define SCR_SPEED_HI        6
`define SCR_SPEED_LO        5
`define SCR_RA_HI           7
`define SCR_RA_LO           5
`define SCR_RB_HI           3
`define SCR_RB_LO           1
`define SCR_DISP_MASK       8'hE0
`define SCR_ROUTE_MASK      8'hEE

// ****************************************
// video timing in half processor cycles, display window base and response codes
// ****************************************
`define SCR_FP_RAS_00       4'd4
`define SCR_FP_RAS_01       4'd6
`define SCR_FP_RAS_10       4'd6
`define SCR_FP_COL_00       4'd4
`define SCR_FP_COL_01       4'd6
`define SCR_FP_COL_10       4'd8
`define SCR_FP_PRE_00       4'd1
`define SCR_FP_PRE_01       4'd1
`define SCR_FP_PRE_10       4'd2
`define SCR_FP_CAS_00       4'd3
`define SCR_FP_CAS_01       4'd3
`define SCR_FP_CAS_10       4'd4
`define SCR_SR_PRE_00       4'd3
`define SCR_SR_PRE_01       4'd4
`define SCR_SR_PRE_10       4'd4
`define SCR_SR_PRE_11       4'd5
`define SCR_SR_CS_00        4'd5
`define SCR_SR_CS_01        4'd6
`define SCR_SR_CS_10        4'd8
`define SCR_SR_CS_11        4'd11
`define SCR_DISP_BASE       20'hB_8000
`define SCR_RESP_OKAY       2'b00
`define SCR_RESP_SLVERR     2'b10

`endif

// >>> scr_pkg.sv
// types shared by the configuration register block
`default_nettype none
package scr_pkg;
    typedef enum logic [2:0] {
        SCR_V_IDLE,
        SCR_V_RAS,
        SCR_V_PRE,
        SCR_V_CAS,
        SCR_V_SPRE,
        SCR_V_CS
    } scr_vid_e;
    typedef logic [3:0] scr_half_t;
endpackage
`default_nettype wire

// >>> system_config_registers_test.sv
// self-checking bench for the configuration register block
`default_nettype none
`include "scr_defines.svh"

module system_config_registers_test;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // clock, reset and design signals
    // ****************************************
    logic        aclk, aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, main_clock_en;
    logic        interrupt_input_a, interrupt_input_b;
    logic        video_req, video_page_hit, video_is_psram;
    logic        display_enable, expansion_owns_display, serial_clock;
    logic [19:0] display_window_base;
    logic [7:0]  irq_lines;
    logic        video_ras, video_cas, video_precharge, video_cs;
    logic        video_done, video_speed_error;
    int          bad_count, cmp_count;
    logic [1:0]  rsp;
    logic [31:0] rd;
    int          hi_n, lo_n;
    int          cnt [4];
    logic        done_seen;

    scr_top #(.ADDR_W(12)) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .main_clock_en(main_clock_en),
        .interrupt_input_a(interrupt_input_a),
        .interrupt_input_b(interrupt_input_b),
        .video_req(video_req), .video_page_hit(video_page_hit),
        .video_is_psram(video_is_psram), .display_enable(display_enable),
        .expansion_owns_display(expansion_owns_display),
        .display_window_base(display_window_base), .irq_lines(irq_lines),
        .serial_clock(serial_clock), .video_ras(video_ras),
        .video_cas(video_cas), .video_precharge(video_precharge),
        .video_cs(video_cs), .video_done(video_done),
        .video_speed_error(video_speed_error)
    );

    always #50 aclk = ~aclk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg,
                     got, exp);
        end
    endtask

    // handshakes are judged at the falling edge, where readies are settled
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        logic ta, tw, tb, fin;
        int   n;
        fin = 0;
        r = 2'bxx;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        for (n = 0; n < 100 && !fin; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid & s_axi_bready;
            if (tb) r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
            fin = tb;
        end
        if (!fin) chk(32'h0, 32'h1, "write never answered");
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic ta, tr, fin;
        int   n;
        fin = 0;
        d = 'x;
        r = 2'bxx;
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        for (n = 0; n < 100 && !fin; n++) begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid & s_axi_rready;
            if (tr) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
            end
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
            fin = tr;
        end
        if (!fin) chk(32'h0, 32'h1, "read never answered");
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // count strobe cycles to the done pulse; more keeps the page open
    task automatic vid(input logic more, input logic ps);
        int n;
        cnt = '{0, 0, 0, 0};
        done_seen = 0;
        if (!video_req) begin
            @(posedge aclk);
            video_req <= 1'b1; video_is_psram <= ps;
        end
        @(posedge aclk);
        video_req <= more; video_page_hit <= more;
        for (n = 0; n < 60 && !done_seen; n++) begin
            @(negedge aclk);
            cnt[0] += int'(video_ras); cnt[1] += int'(video_cas);
            cnt[2] += int'(video_precharge); cnt[3] += int'(video_cs);
            done_seen = (video_done === 1'b1);
        end
    endtask

    // skip one period so a new divider setting is in force, then measure
    task automatic ser_measure();
        int n;
        for (int k = 0; k < 4; k++)
            for (n = 0; n < 200 && serial_clock !== k[0]; n++) @(negedge aclk);
        for (hi_n = 0; hi_n < 40 && serial_clock === 1'b1; hi_n++)
            @(negedge aclk);
        for (lo_n = 0; lo_n < 40 && serial_clock === 1'b0; lo_n++)
            @(negedge aclk);
    endtask

    function automatic logic [7:0] irq_for(input int c);
        return (c == 0 || c == 2) ? 8'h00 : 8'(1 << c);
    endfunction

    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************
    // register rows: address, written, read back, response
    // ****************************************
    typedef struct { logic [11:0] a; logic [31:0] w, r; logic [1:0] s; }
        scr_row_s;
    scr_row_s rows [6] = '{
        '{12'h01C, 32'h0000_00FF, 32'h0000_00E0, 2'b00},
        '{12'h01C, 32'h0000_0020, 32'h0000_0020, 2'b00},
        '{12'h020, 32'hFFFF_FFFF, 32'h0000_00EE, 2'b00},
        '{12'h03C, 32'h0000_00A5, 32'h0000_00A5, 2'b00},
        '{12'h03C, 32'h0000_0088, 32'h0000_0088, 2'b00},
        '{12'h100, 32'h0000_0012, 32'h0000_0000, 2'b10}
    };
    int ras_t [3] = '{4, 6, 6};
    int col_t [3] = '{4, 6, 8};
    int pre_t [3] = '{1, 1, 2};
    int cas_t [3] = '{3, 3, 4};
    int spre_t [4] = '{3, 4, 4, 5};
    int scs_t [4] = '{5, 6, 8, 11};
    logic [7:0] div_t [3] = '{8'h00, 8'hFF, 8'h27};

    initial begin
        aclk = 0; aresetn = 0; s_axi_awaddr = 0; s_axi_awvalid = 0;
        s_axi_wdata = 0; s_axi_wstrb = 0; s_axi_wvalid = 0; s_axi_bready = 0;
        s_axi_araddr = 0; s_axi_arvalid = 0; s_axi_rready = 0;
        main_clock_en = 1; interrupt_input_a = 0; interrupt_input_b = 0;
        video_req = 0; video_page_hit = 0; video_is_psram = 0;
        bad_count = 0; cmp_count = 0;
        do_reset();
        foreach (rows[i]) begin
            axi_write(rows[i].a, rows[i].w, rsp);
            chk(rsp, rows[i].s, "write response");
            axi_read(rows[i].a, rd, rsp);
            chk(rsp, rows[i].s, "read response");
            chk(rd, rows[i].r, "read data");
        end
        $display("register rows done");
        // ****************************************
        // hand-written cases
        // ****************************************
        axi_write(12'h01C, 32'h0000_0080, rsp);
        @(negedge aclk);
        chk(display_enable, 1'b0, "display stopped");
        chk(expansion_owns_display, 1'b1, "window released");
        chk(display_window_base, 20'hB_8000, "window base");
        $display("display test done");
        for (int c = 0; c < 8; c++) begin
            axi_write(12'h020, 32'(c << 5), rsp);
            interrupt_input_a <= 1'b1;
            repeat (3) @(posedge aclk);
            chk(irq_lines, irq_for(c), "line a route");
            interrupt_input_a <= 1'b0;
            axi_write(12'h020, 32'(c << 1), rsp);
            interrupt_input_b <= 1'b1;
            repeat (3) @(posedge aclk);
            chk(irq_lines, irq_for(c), "line b route");
            interrupt_input_b <= 1'b0;
        end
        $display("interrupt routing test done");
        foreach (div_t[i]) begin
            axi_write(12'h03C, 32'(div_t[i]), rsp);
            ser_measure();
            chk(hi_n, div_t[i][7:4] + 1, "serial high time");
            chk(lo_n, div_t[i][3:0] + 1, "serial low time");
            chk(hi_n + lo_n, div_t[i][7:4] + div_t[i][3:0] + 2, "period");
        end
        $display("serial divider test done");
        for (int c = 0; c < 4; c++) begin
            axi_write(12'h01C, 32'(c << 5), rsp);
            if (c < 3) begin
                vid(1'b1, 1'b0);
                chk(done_seen, 1'b1, "first access done");
                chk(cnt[0], ras_t[c], "ras length");
                chk(cnt[1], col_t[c], "first cas length");
                vid(1'b0, 1'b0);
                chk(cnt[0], 0, "page access without ras");
                chk(cnt[2], pre_t[c], "precharge length");
                chk(cnt[1], cas_t[c], "page cas length");
            end
            vid(1'b0, 1'b1);
            chk(cnt[2], spre_t[c], "static precharge");
            chk(cnt[3], scs_t[c], "chip select length");
        end
        // page mode has no timing for code 11, so no access is made
        vid(1'b0, 1'b0);
        chk(done_seen, 1'b0, "refused access");
        chk(video_speed_error, 1'b1, "speed error flag");
        axi_read(12'h040, rd, rsp);
        chk(rd[2], 1'b1, "status error bit");
        $display("video timing test done");
        // second reset in mid-run restores every default
        do_reset();
        @(negedge aclk);
        chk(display_enable, 1'b1, "display after reset");
        chk(serial_clock, 1'b1, "serial clock after reset");
        axi_read(12'h01C, rd, rsp);
        chk(rd, 32'h0000_0000, "display default");
        axi_read(12'h020, rd, rsp);
        chk(rd, 32'h0000_0000, "route default");
        chk(irq_lines, 8'h00, "no irq after reset");
        axi_read(12'h03C, rd, rsp);
        chk(rd, 32'h0000_0088, "divider default");
        $display("reset test done");
        summarize();
    end

    initial begin
        #5_000_000;
        bad_count++;
        $display("unexpected at %0t: run hung", $time);
        summarize();
    end
endmodule
`default_nettype wire
